/* src/cotc_pkg.sv */
/*
  cotc_pkg: register map, field positions, reset values, timing counts
  and shared types of the constant off-time chopper block.
  assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package cotc_pkg;
  ////////////////////////////////////////////////////////////////////////
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] ADDR_CHOP   = 8'h00;
  localparam logic [7:0] ADDR_CURR   = 8'h04;
  localparam logic [7:0] ADDR_GSCALE = 8'h08;
  localparam logic [7:0] ADDR_STAT   = 8'h0C;

  // chopper configuration fields
  localparam int TOFF_LSB    = 0;
  localparam int FD_LSB      = 4;
  localparam int OFS_LSB     = 8;
  localparam int DISFDCC_BIT = 12;
  localparam int CHSEL_BIT   = 13;
  localparam int BLANK_LSB   = 16;
  // current configuration fields
  localparam int HOLD_LSB    = 0;
  localparam int RUN_LSB     = 8;
  // status fields
  localparam int STAT_CS_LSB = 0;
  localparam int STAT_CL_BIT = 5;
  localparam int STAT_PH_LSB = 8;

  localparam logic [31:0] CHOP_RST   = 32'h0001_2343;
  localparam logic [31:0] CURR_RST   = 32'h0000_1F10;
  localparam logic [7:0]  GSCALE_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [9:0] SLOW_UNIT  = 10'h020;
  localparam logic [9:0] SLOW_BASE  = 10'h018;
  localparam logic [9:0] FAST_UNIT  = 10'h020;
  localparam logic [9:0] BLANK_UNIT = 10'h010;

  localparam logic [3:0] SINE_OFS_ZERO = 4'h3;
  localparam logic [8:0] GS_FULL       = 9'h100;
  localparam int         TGT_LSB       = 13;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ON   = 2'b01,
    PH_FAST = 2'b10,
    PH_SLOW = 2'b11
  } cotc_phase_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cotc_apb_req_s;

  typedef struct packed {
    logic on;
    logic fast;
    logic slow;
    logic polarity;
  } cotc_drive_s;
endpackage

/* src/cotc_sync3.sv */
/*
  cotc_sync3: three-stage input synchroniser with agreement filter.
  assumes d comes from outside the clk domain.
*/
`timescale 1ns/1ps
module cotc_sync3 (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin and result
  input  wire logic d,
  output logic      q
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // one stage of agreement filters single-cycle glitches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (s2 == s3) begin
      q <= s3;
    end
  end

  a_sync_agree: assert property (@(posedge clk) disable iff (!rst_n)
    (q != $past(q)) |-> $past(s2 == s3))
    else $error("sync output changed without agreement");
endmodule

/* src/cotc_target_calc.sv */
/*
  cotc_target_calc: coil current target from global scaler, sine value,
  current scale and sine offset.
  assumes the sine value is a signed table sample of amplitude 248.
*/
`timescale 1ns/1ps
module cotc_target_calc (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // operands
  input  wire logic [7:0]        gsCode,
  input  wire logic signed [8:0] sineValue,
  input  wire logic [4:0]        csActual,
  input  wire logic [3:0]        offsetCode,
  input  wire logic              classic,
  // result
  output logic [9:0]             targetCurrent,
  output logic                   polarity
);
  logic [8:0]         mag;
  logic signed [4:0]  ofs;
  logic signed [10:0] sum;
  logic [9:0]         magAdj;
  logic [8:0]         gsEff;
  logic [24:0]        prod;

  assign mag    = sineValue[8] ? 9'(-sineValue) : 9'(sineValue);
  assign ofs    = classic ? ($signed({1'b0, offsetCode})
                  - $signed({1'b0, cotc_pkg::SINE_OFS_ZERO})) : 5'sd0;
  assign sum    = $signed({2'b00, mag}) + 11'(ofs);
  assign magAdj = sum[10] ? 10'h000 : sum[9:0];
  assign gsEff  = (gsCode == 8'h00) ? cotc_pkg::GS_FULL : {1'b0, gsCode};
  // gs/256 * sine/248 * (cs+1)/32, the 248 lives in the table amplitude
  assign prod   = 25'(gsEff) * 25'(magAdj) * 25'({1'b0, csActual} + 6'h01);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      targetCurrent <= 10'h000;
      polarity      <= 1'b0;
    end else begin
      targetCurrent <= prod[cotc_pkg::TGT_LSB +: 10];
      polarity      <= sineValue[8];
    end
  end

  a_gs_zero_full: assert property (@(posedge clk) disable iff (!rst_n)
    (gsCode == 8'h00) |-> (gsEff == 9'h100))
    else $error("zero global scaler not full scale");
  a_offset_code: assert property (@(posedge clk) disable iff (!rst_n)
    classic |-> (sum == $signed({2'b00, mag}) + $signed({7'h00, offsetCode}) - 11'sd3))
    else $error("sine offset not code minus three");
endmodule

/* src/cotc_chopper.sv */
/*
  cotc_chopper: constant off-time chopper for one coil with APB registers
  and current scale selection.
  assumes comparator pins are asynchronous and the mode inputs
  (standstill, load speed fullstep, adaptive current) come from logic on clk.
*/
`timescale 1ns/1ps
// Function
// - an on phase is followed by a configured-length fast decay unless that length is zero
// - on phase ends when the current comparator reports target reached
// - load-dependent speed fullstepping forces the classic chopper
// - fast decay length zero means slow decay only, else sets duration
// - sine offset equals field value minus three
// - comparator may end fast decay early unless disable bit is set
// - global scaler zero counts as 256, else steps of 1/256
// - software sets an 8-bit global current scaler
// - 5-bit current scale from run, hold or adaptive control
// - applied current scale readable in a read-only status field
// - target is scaler/256 times sine/248 times (scale+1)/32
// - comparator ignored during blanking in on and fast decay
// - run and hold settings scale current in 1/32 steps up to 32/32
module cotc_chopper #(
  parameter int CNT_W = 10
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // apb slave
  input  wire cotc_pkg::cotc_apb_req_s apbReq,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // motion side inputs
  input  wire logic signed [8:0]     sineValue,
  input  wire logic                  standstill,
  input  wire logic                  loadSpeedFull,
  input  wire logic                  coolEnable,
  input  wire logic [4:0]            coolScale,
  // comparator pins
  input  wire logic                  currentReachedPin,
  input  wire logic                  negCurrentPin,
  // bridge and current outputs
  output cotc_pkg::cotc_drive_s      drive,
  output logic [9:0]                 targetCurrent,
  output logic [4:0]                 csActual
);
  ////////////////////////////////////////////////////////////////////////
  if (CNT_W < 10) begin : g_chk
    $error("CNT_W too small for longest phase");
  end

  logic [31:0]           chopCfg_r;
  logic [31:0]           currCfg_r;
  logic [7:0]            gScale_r;
  logic                  setupPh;
  logic                  accessWr;
  logic                  mapped;
  logic [31:0]           rdMux;
  logic [3:0]            toff;
  logic [3:0]            fdLen;
  logic [3:0]            ofsCode;
  logic                  disfdcc;
  logic                  chSel;
  logic [1:0]            blank;
  logic [4:0]            runScale;
  logic [4:0]            holdScale;
  logic                  classicActive;
  logic                  compReached;
  logic                  negExceeded;
  cotc_pkg::cotc_phase_e phase_r;
  cotc_pkg::cotc_phase_e phase_nxt;
  logic [CNT_W-1:0]      cnt_r;
  logic [CNT_W-1:0]      blankLen;
  logic [CNT_W-1:0]      fastLen;
  logic [CNT_W-1:0]      slowLen;
  logic                  blankDone;
  logic                  polarity;
  logic [4:0]            csSel;

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign setupPh  = apbReq.psel & ~apbReq.penable;
  assign accessWr = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign mapped   = (apbReq.paddr == cotc_pkg::ADDR_CHOP)
                  | (apbReq.paddr == cotc_pkg::ADDR_CURR)
                  | (apbReq.paddr == cotc_pkg::ADDR_GSCALE)
                  | (apbReq.paddr == cotc_pkg::ADDR_STAT);
  assign pready   = 1'b1;
  assign pslverr  = apbReq.psel & apbReq.penable & ~mapped;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chopCfg_r <= cotc_pkg::CHOP_RST;
      currCfg_r <= cotc_pkg::CURR_RST;
      gScale_r  <= cotc_pkg::GSCALE_RST;
    end else if (accessWr) begin
      case (apbReq.paddr)
        cotc_pkg::ADDR_CHOP: begin
          chopCfg_r <= apbReq.pwdata & 32'h0003_3FFF;
        end
        cotc_pkg::ADDR_CURR: begin
          currCfg_r <= apbReq.pwdata & 32'h0000_1F1F;
        end
        cotc_pkg::ADDR_GSCALE: begin
          gScale_r <= apbReq.pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    case (apbReq.paddr)
      cotc_pkg::ADDR_CHOP: begin
        rdMux = chopCfg_r;
      end
      cotc_pkg::ADDR_CURR: begin
        rdMux = currCfg_r;
      end
      cotc_pkg::ADDR_GSCALE: begin
        rdMux = {24'h00_0000, gScale_r};
      end
      cotc_pkg::ADDR_STAT: begin
        rdMux[cotc_pkg::STAT_CS_LSB +: 5] = csActual;
        rdMux[cotc_pkg::STAT_CL_BIT]      = classicActive;
        rdMux[cotc_pkg::STAT_PH_LSB +: 2] = phase_r;
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
  end

  // read data latched in setup so it stands through the access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPh & ~apbReq.pwrite) begin
      prdata <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration fields
  assign toff      = chopCfg_r[cotc_pkg::TOFF_LSB +: 4];
  assign fdLen     = chopCfg_r[cotc_pkg::FD_LSB +: 4];
  assign ofsCode   = chopCfg_r[cotc_pkg::OFS_LSB +: 4];
  assign disfdcc   = chopCfg_r[cotc_pkg::DISFDCC_BIT];
  assign chSel     = chopCfg_r[cotc_pkg::CHSEL_BIT];
  assign blank     = chopCfg_r[cotc_pkg::BLANK_LSB +: 2];
  assign runScale  = currCfg_r[cotc_pkg::RUN_LSB +: 5];
  assign holdScale = currCfg_r[cotc_pkg::HOLD_LSB +: 5];

  assign classicActive = chSel | loadSpeedFull;

  // scale code n means (n+1)/32, so 31 is full current
  always_comb begin
    csSel = runScale;
    if (standstill) begin
      csSel = holdScale;
    end else if (coolEnable && (coolScale < runScale)) begin
      csSel = coolScale;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      csActual <= 5'h00;
    end else begin
      csActual <= csSel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  cotc_sync3 u_syncReached (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (currentReachedPin),
    .q     (compReached)
  );

  cotc_sync3 u_syncNeg (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (negCurrentPin),
    .q     (negExceeded)
  );

  cotc_target_calc u_calc (
    .clk           (clk),
    .rst_n         (rst_n),
    .gsCode        (gScale_r),
    .sineValue     (sineValue),
    .csActual      (csActual),
    .offsetCode    (ofsCode),
    .classic       (classicActive),
    .targetCurrent (targetCurrent),
    .polarity      (polarity)
  );

  ////////////////////////////////////////////////////////////////////////
  // phase lengths; a zero off time disables the bridge
  assign blankLen  = CNT_W'(({8'h00, blank} + 10'h001) * cotc_pkg::BLANK_UNIT);
  assign fastLen   = CNT_W'(10'(fdLen) * cotc_pkg::FAST_UNIT);
  assign slowLen   = CNT_W'(10'(toff) * cotc_pkg::SLOW_UNIT + cotc_pkg::SLOW_BASE);
  assign blankDone = (cnt_r >= blankLen);

  always_comb begin
    phase_nxt = phase_r;
    if (!classicActive || (toff == 4'h0)) begin
      phase_nxt = cotc_pkg::PH_IDLE;
    end else begin
      case (phase_r)
        cotc_pkg::PH_IDLE: begin
          phase_nxt = cotc_pkg::PH_ON;
        end
        cotc_pkg::PH_ON: begin
          if (blankDone && compReached) begin
            phase_nxt = (fdLen == 4'h0) ? cotc_pkg::PH_SLOW
                                        : cotc_pkg::PH_FAST;
          end
        end
        cotc_pkg::PH_FAST: begin
          if (cnt_r == fastLen - 1'b1) begin
            phase_nxt = cotc_pkg::PH_SLOW;
          end else if (!disfdcc && blankDone && negExceeded) begin
            phase_nxt = cotc_pkg::PH_SLOW;
          end
        end
        cotc_pkg::PH_SLOW: begin
          if (cnt_r == slowLen - 1'b1) begin
            phase_nxt = cotc_pkg::PH_ON;
          end
        end
        default: begin
          phase_nxt = cotc_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_r <= cotc_pkg::PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // counter saturates so a stuck comparator cannot wrap the blanking check
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (phase_nxt != phase_r) begin
      cnt_r <= '0;
    end else if (cnt_r != {CNT_W{1'b1}}) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive <= '0;
    end else begin
      drive.on       <= (phase_nxt == cotc_pkg::PH_ON);
      drive.fast     <= (phase_nxt == cotc_pkg::PH_FAST);
      drive.slow     <= (phase_nxt == cotc_pkg::PH_SLOW);
      drive.polarity <= polarity;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_onExit;
    (phase_r == cotc_pkg::PH_ON) ##1 (phase_r != cotc_pkg::PH_ON);
  endsequence

  a_fast_after_on: assert property (@(posedge clk) disable iff (!rst_n)
    s_onExit ##0 ($past(fdLen != 4'h0) && classicActive) |->
    (phase_r == cotc_pkg::PH_FAST))
    else $error("on phase not followed by fast decay");
  a_fd_zero_slow: assert property (@(posedge clk) disable iff (!rst_n)
    s_onExit ##0 ($past(fdLen == 4'h0) && classicActive) |->
    (phase_r == cotc_pkg::PH_SLOW))
    else $error("zero fast decay did not skip to slow decay");
  a_on_end_comp: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_r == cotc_pkg::PH_ON) && (phase_nxt != cotc_pkg::PH_ON) && classicActive
    && (toff != 4'h0) |-> compReached && (cnt_r >= blankLen))
    else $error("on phase ended without comparator or inside blanking");
  a_fast_blanked: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_r == cotc_pkg::PH_FAST) && (phase_nxt == cotc_pkg::PH_SLOW)
    && (cnt_r < blankLen) |-> (cnt_r == fastLen - 1'b1))
    else $error("fast decay ended by comparator during blanking");
  a_fast_time_only: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_r == cotc_pkg::PH_FAST) && disfdcc && (phase_nxt == cotc_pkg::PH_SLOW)
    |-> (cnt_r == fastLen - 1'b1))
    else $error("fast decay ended early with comparator disabled");
  a_slow_length: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_r == cotc_pkg::PH_SLOW) && (phase_nxt == cotc_pkg::PH_ON)
    |-> (cnt_r == slowLen - 1'b1))
    else $error("slow decay length wrong");
  a_classic_forced: assert property (@(posedge clk) disable iff (!rst_n)
    loadSpeedFull && (toff != 4'h0) && (phase_r == cotc_pkg::PH_IDLE) |=>
    (phase_r == cotc_pkg::PH_ON) || !loadSpeedFull || (toff == 4'h0))
    else $error("classic chopper not forced in fullstep mode");
  a_cs_status: assert property (@(posedge clk) disable iff (!rst_n)
    setupPh && !apbReq.pwrite && (apbReq.paddr == cotc_pkg::ADDR_STAT) |=>
    (prdata[4:0] == $past(csActual)))
    else $error("status does not show applied current scale");
  a_hold_select: assert property (@(posedge clk) disable iff (!rst_n)
    standstill |=> (csActual == $past(holdScale)))
    else $error("hold scale not applied at standstill");
endmodule

/* bench/cotc_bridge_model.sv */
/*
  cotc_bridge_model: bridge plus sense comparator seen by one coil.
  assumes drive comes from the chopper on clk; comparators are push-pull, low when idle.
*/
`timescale 1ns/1ps
module cotc_bridge_model (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // bridge command
  input  wire cotc_pkg::cotc_drive_s drive,
  // bench control
  input  wire logic [7:0]            respDelay,
  input  wire logic                  negEnable,
  // comparator pins
  output logic                       currentReachedPin,
  output logic                       negCurrentPin
);
  logic [7:0] onCnt_r;
  logic [7:0] fastCnt_r;
  ////////////////////////////////////////////////////////////////////////
  // current rises while on; slow response models a large inductance
  always_ff @(posedge clk) begin
    if (!rst_n || !drive.on) onCnt_r <= 8'h00;
    else if (onCnt_r != 8'hFF) onCnt_r <= onCnt_r + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || !drive.fast) fastCnt_r <= 8'h00;
    else if (fastCnt_r != 8'hFF) fastCnt_r <= fastCnt_r + 8'h01;
  end
  assign currentReachedPin = drive.on && (onCnt_r >= respDelay);
  // overshoot into negative current only when the bench asks for it
  assign negCurrentPin = drive.fast && negEnable && (fastCnt_r >= 8'h04);
endmodule

/* bench/cotc_chopper_tb.sv */
/*
  cotc_chopper_tb: self-checking bench of the chopper and current path.
  assumes the bridge model on the comparator pins; apb slave is zero wait.
*/
`timescale 1ns/1ps
module cotc_chopper_tb;
  logic clk, rst_n, standstill, loadSpeedFull, coolEnable, negEnable, pready, pslverr;
  logic cReach, cNeg, err;
  logic signed [8:0]      sineValue;
  logic [4:0]             coolScale, csActual;
  logic [7:0]             respDelay;
  logic [9:0]             targetCurrent;
  logic [31:0]            prdata, rd;
  cotc_pkg::cotc_apb_req_s apbReq;
  cotc_pkg::cotc_drive_s  drive;
  int error_cnt, checks, n;

  cotc_chopper i_cotc_chopper (.clk(clk), .rst_n(rst_n), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sineValue(sineValue), .standstill(standstill),
    .loadSpeedFull(loadSpeedFull), .coolEnable(coolEnable), .coolScale(coolScale),
    .currentReachedPin(cReach), .negCurrentPin(cNeg), .drive(drive),
    .targetCurrent(targetCurrent), .csActual(csActual));
  cotc_bridge_model i_cotc_bridge_model (.clk(clk), .rst_n(rst_n), .drive(drive),
    .respDelay(respDelay), .negEnable(negEnable), .currentReachedPin(cReach),
    .negCurrentPin(cNeg));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer; waits for pready at the access edge
  // only the watchdog ends a wait for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
  endtask
  function automatic logic [31:0] chop(int toff, int fd, int ofs, int dis, int sel);
    return 32'(toff | (fd << 4) | (ofs << 8) | (dis << 12) | (sel << 13));
  endfunction
  function automatic logic ph(int k);
    return (k == 0) ? drive.on : (k == 1) ? drive.fast : drive.slow;
  endfunction
  // waits for a phase to start, then counts its cycles
  task automatic measure(input int k);
    int m;
    m = 0;
    while (ph(k) !== 1'b1 && m < 2000) begin
      @(posedge clk);
      m++;
    end
    n = 0;
    while (ph(k) === 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (m >= 2000 || n >= 2000) begin
      error_cnt++;
      $display("[ERR] %0t phase wait limit reached", $time);
    end
  endtask
  function automatic int expTarget(int gs, int s, int cs, int ofs, int classic);
    int mag;
    mag = ((s < 0) ? -s : s) + (classic ? ofs - 3 : 0);
    if (mag < 0) mag = 0;
    return ((gs == 0 ? 256 : gs) * mag * (cs + 1)) >> 13;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    int gs, s, h, r, c, o, sel, cs;
    apbReq = '0; standstill = 0; loadSpeedFull = 0; coolEnable = 0; coolScale = 0;
    sineValue = 0; respDelay = 8'h28; negEnable = 0; rst_n = 0; error_cnt = 0; checks = 0;
    void'($urandom(32'h908D));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped address
    apb(0, cotc_pkg::ADDR_CHOP, 0);   chk(rd, cotc_pkg::CHOP_RST);
    apb(0, cotc_pkg::ADDR_CURR, 0);   chk(rd, cotc_pkg::CURR_RST);
    apb(0, cotc_pkg::ADDR_GSCALE, 0); chk(rd, 32'h0);
    apb(0, 8'h10, 0);                 chk({rd[30:0], err}, 32'h1);
    $display("test registers done");
    // scale selection and target current, corners first
    for (int i = 0; i < 40; i++) begin
      gs = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(255);
      s = (i == 0) ? 248 : (i == 1) ? -248 : $urandom_range(496) - 248;
      h = $urandom_range(31); r = (i < 2) ? 31 : $urandom_range(31);
      c = $urandom_range(31); o = $urandom_range(15); sel = $urandom_range(1);
      apb(1, cotc_pkg::ADDR_CURR, 32'(h | (r << 8)));
      apb(1, cotc_pkg::ADDR_GSCALE, 32'(gs));
      apb(0, cotc_pkg::ADDR_GSCALE, 0); chk(rd, 32'(gs));
      apb(1, cotc_pkg::ADDR_CHOP, chop(1, 1, o, 1, sel));
      @(posedge clk);
      standstill <= (i > 1) && ($urandom_range(3) == 0);
      coolEnable <= $urandom_range(1);
      coolScale <= 5'(c);
      sineValue <= 9'(s);
      repeat (5) @(posedge clk);
      cs = standstill ? h : (coolEnable && c < r) ? c : r;
      chk(csActual, 32'(cs));
      chk(targetCurrent, 32'(expTarget(gs, s, cs, o, sel)));
      apb(0, cotc_pkg::ADDR_STAT, 0); chk(rd[4:0], 32'(cs));
    end
    $display("test current done");
    // chopper timing with toff 1, blank 16
    apb(1, cotc_pkg::ADDR_CHOP, chop(1, 2, 3, 1, 1));
    // run to the end of a slow phase so the first on phase is seen whole
    measure(2);
    measure(0); chk(n >= 40, 1);
    measure(1); chk(n, 64);
    measure(2); chk(n, 56);
    respDelay <= 8'h02;
    measure(0); measure(0); chk(n >= 16 && n <= 24, 1);
    apb(1, cotc_pkg::ADDR_CHOP, chop(1, 0, 3, 1, 1));
    measure(0); measure(0); chk({ph(1), ph(2)}, 32'h1);
    negEnable <= 1'b1;
    apb(1, cotc_pkg::ADDR_CHOP, chop(1, 3, 3, 1, 1));
    measure(1); measure(1); chk(n, 96);
    apb(1, cotc_pkg::ADDR_CHOP, chop(1, 3, 3, 0, 1));
    measure(1); measure(1); chk(n >= 16 && n < 30, 1);
    negEnable <= 1'b0;
    $display("test classic done");
    // fullstepping forces the classic chopper
    apb(1, cotc_pkg::ADDR_CHOP, chop(1, 1, 3, 1, 0));
    repeat (4) @(posedge clk);
    chk(drive, 32'({3'b000, sineValue[8]}));
    loadSpeedFull <= 1'b1;
    measure(1); chk(n, 32);
    apb(0, cotc_pkg::ADDR_STAT, 0); chk(rd[5], 32'h1);
    $display("test fullstep done");
    end_of_test();
  end
endmodule
